// ==== common/ast_regs.vh ====
// register map, field positions, reset values and timing counts
`ifndef AST_REGS_VH
`define AST_REGS_VH

`define AST_OFS_STATUS 8'h00
`define AST_OFS_FRAME 8'h04
`define AST_OFS_DIRIRQ 8'h08
`define AST_OFS_BAUD 8'h0C
`define AST_OFS_DATA 8'h10

`define AST_RST_STATUS 8'h0B
`define AST_RST_FRAME 8'h00
`define AST_RST_DIRIRQ 8'h00
`define AST_RST_BAUD 8'h00

`define AST_FC_ENABLE 7
`define AST_FC_NINE 6
`define AST_FC_PAREN 5
`define AST_FC_PARODD 4
`define AST_FC_TWOSTOP 3
`define AST_FC_BREAK 2
`define AST_FC_RXBIT8 1
`define AST_FC_TXBIT8 0
`define AST_FC_WMASK 8'hFD

`define AST_DC_TRANSMITTER_ENABLE 7
`define AST_DC_RECEIVER_ENABLE 6
`define AST_DC_HSPEED 5
`define AST_DC_ADDR 4
`define AST_DC_WAKE 3
`define AST_DC_RXIE 2
`define AST_DC_TIDLEIE 1
`define AST_DC_TEMPTYIE 0

`define AST_OVS_LAST 4'hF
`define AST_SMP_A 4'h7
`define AST_SMP_B 4'h8
`define AST_SMP_C 4'h9
`define AST_LOWSPEED_LAST 2'h3

`define AST_RESP_OKAY 2'h0
`define AST_RESP_SLVERR 2'h2

`endif

// ==== design/ast_uart.v ====
// asynchronous serial transceiver with an axi4-lite register slave
//
// Implementation choices: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps
// How it works
// - frames carry eight or nine data bits, chosen by a control bit.
// - even, odd or no parity, shared by transmitter and receiver.
// - transmitter ends each frame with one or two stop bits.
// - both directions are timed by an 8-bit programmable baud divisor.
// - received characters wait in a two-entry receive buffer.
// - with address detect on, receive interrupt needs last data bit one.
// - a low receive line can raise a wake request when enabled.
// - one interrupt output ORs all enabled transmit and receive sources.
// - enabled directions drive transmit, take receive, and drop pull-ups.
// - disabled directions float their pin and leave pull-ups alone.
// - written data moves to a hidden shifter, sent LSB first.
// - receive line shifts in LSB first, full word moves to buffer.
// - one data address: write loads transmit, read gives oldest word.
// - status flags are read-only and reset to 0x0B.
// - parity error set on mismatch, never with parity disabled.
// - parity error clears by status read then data access.
// - noise flag set with data-available, not on overrun; same clear.
// - framing error set on a bad stop bit; same clear.
// - overrun set on buffer overflow and blocks transfers until cleared.
// - parity, noise and framing flags rise in the cycle the word enters the buffer.
// - enabling the transmitter shows the transmit register empty.
`include "ast_regs.vh"

module ast_uart #(
    parameter ADDR_W = 8,
    parameter RX_DEPTH = 2,
    parameter RX_PW = 1
) (
    input wire clk,
    input wire sys_rst,
    input wire [ADDR_W-1:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [ADDR_W-1:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    output reg txOut,
    output reg txOe,
    output reg txPullDis,
    input wire rxIn,
    output reg rxPullDis,
    output reg irqReq,
    output reg wakeReq
);
    localparam RX_IDLE = 4'b0001;
    localparam RX_START = 4'b0010;
    localparam RX_DATA = 4'b0100;
    localparam RX_STOP = 4'b1000;

    // 0 status, 1 frame, 2 dir/irq, 3 baud, 4 data, 7 unmapped
    function [2:0] regSel;
        input [ADDR_W-1:0] a;
        begin
            if (a == `AST_OFS_STATUS)
                regSel = 3'h0;
            else if (a == `AST_OFS_FRAME)
                regSel = 3'h1;
            else if (a == `AST_OFS_DIRIRQ)
                regSel = 3'h2;
            else if (a == `AST_OFS_BAUD)
                regSel = 3'h3;
            else if (a == `AST_OFS_DATA)
                regSel = 3'h4;
            else
                regSel = 3'h7;
        end
    endfunction

    reg [7:0] frameCtl_ff;
    reg [7:0] dirCtl_ff;
    reg [7:0] baudDiv_ff;
    reg [ADDR_W-1:0] awAddr_ff;
    reg [7:0] wData_ff;
    reg wLane0_ff;
    reg statusArmed_ff;
    reg parity_error_flag_ff, noise_ff, framing_error_flag_ff, overrun_flag_ff;
    reg [7:0] divCnt_ff;
    reg [1:0] preCnt_ff;
    reg [8:0] txHold_ff;
    reg txFull_ff;
    reg [12:0] txSh_ff;
    reg [3:0] txLeft_ff;
    reg [3:0] txTick_ff;
    reg txBusy_ff;
    reg rxMeta_ff, rxSync_ff, rxPrev_ff;
    reg [3:0] rxState_ff;
    reg [3:0] rxTick_ff;
    reg [3:0] rxIdx_ff;
    reg [9:0] rxSh_ff;
    reg [1:0] smp_ff;
    reg rxNoise_ff;
    reg [11:0] rxMem [0:RX_DEPTH-1];
    reg [RX_PW-1:0] rxWr_ff, rxRd_ff;
    reg [RX_PW:0] rxCount_ff;

    wire enable = frameCtl_ff[`AST_FC_ENABLE];
    wire nine = frameCtl_ff[`AST_FC_NINE];
    wire parEn = frameCtl_ff[`AST_FC_PAREN];
    wire parOdd = frameCtl_ff[`AST_FC_PARODD];
    wire transmitter_enable = enable & dirCtl_ff[`AST_DC_TRANSMITTER_ENABLE];
    wire receiver_enable = enable & dirCtl_ff[`AST_DC_RECEIVER_ENABLE];
    wire doWrite = !s_axi_awready & !s_axi_wready & !s_axi_bvalid;
    wire [2:0] wrSel = regSel(awAddr_ff);
    wire doRead = s_axi_arvalid & s_axi_arready;
    wire [2:0] rdSel = regSel(s_axi_araddr);
    wire dataRead = doRead & (rdSel == 3'h4);
    wire dataWrite = doWrite & (wrSel == 3'h4) & wLane0_ff;
    wire dataAccess = dataRead | dataWrite;
    // sequence clear: a status read must come first
    wire seqClear = dataAccess & statusArmed_ff;
    wire rxAvail = (rxCount_ff != {(RX_PW+1){1'b0}});
    wire rxFullBuf = (rxCount_ff == RX_DEPTH[RX_PW:0]);
    wire [11:0] rxHead = rxMem[rxRd_ff];
    wire headMsb = nine ? rxHead[8] : rxHead[7];
    wire txEmpty = !txFull_ff;
    wire txIdle = !txBusy_ff & !txFull_ff;
    wire rxIdle = (rxState_ff == RX_IDLE);
    wire [7:0] status = {parity_error_flag_ff, noise_ff, framing_error_flag_ff, overrun_flag_ff,
                         rxIdle, rxAvail, txIdle, txEmpty};

    wire preLast = dirCtl_ff[`AST_DC_HSPEED] |
                   (preCnt_ff == `AST_LOWSPEED_LAST);
    wire tick = enable & (divCnt_ff == 8'h00) & preLast;
    always @(posedge clk) begin
        if (sys_rst || !enable) begin
            divCnt_ff <= 8'h00;
            preCnt_ff <= 2'h0;
        end else if (divCnt_ff == 8'h00) begin
            divCnt_ff <= baudDiv_ff;
            preCnt_ff <= preCnt_ff + 2'h1;
        end else begin
            divCnt_ff <= divCnt_ff - 8'h01;
        end
    end

    // data bit count; parity appended when enabled
    reg [12:0] txFrame;
    reg [3:0] nBits;
    reg [3:0] txTotal;
    reg [8:0] txMasked;
    integer i;
    always @* begin
        nBits = nine ? 4'h9 : 4'h8;
        txMasked = nine ? txHold_ff : {1'b0, txHold_ff[7:0]};
        txFrame = 13'h1FFF;
        txFrame[0] = 1'b0;
        for (i = 0; i < 9; i = i + 1) begin
            if (i < nBits)
                txFrame[i+1] = txHold_ff[i];
        end
        if (parEn)
            txFrame[nBits+4'h1] = (^txMasked) ^ parOdd;
        txTotal = 4'h1 + nBits + {3'h0, parEn} +
                  (frameCtl_ff[`AST_FC_TWOSTOP] ? 4'h2 : 4'h1);
    end

    // holding register feeds a hidden shifter, LSB first
    always @(posedge clk) begin
        if (sys_rst || !enable) begin
            txHold_ff <= 9'h000;
            txFull_ff <= 1'b0;
            txSh_ff <= 13'h1FFF;
            txLeft_ff <= 4'h0;
            txTick_ff <= 4'h0;
            txBusy_ff <= 1'b0;
        end else begin
            // cleared holding register reads as empty
            if (!transmitter_enable)
                txFull_ff <= 1'b0;
            else if (!txBusy_ff && txFull_ff)
                txFull_ff <= 1'b0;
            else if (dataWrite && !txFull_ff)
                txFull_ff <= 1'b1;
            // data write loads the transmit side
            if (dataWrite && transmitter_enable && !txFull_ff)
                txHold_ff <= {frameCtl_ff[`AST_FC_TXBIT8], wData_ff};
            if (!txBusy_ff && txFull_ff && transmitter_enable) begin
                txSh_ff <= txFrame;
                txLeft_ff <= txTotal;
                txTick_ff <= 4'h0;
                txBusy_ff <= 1'b1;
            end else if (txBusy_ff && tick) begin
                txTick_ff <= txTick_ff + 4'h1;
                if (txTick_ff == `AST_OVS_LAST) begin
                    txSh_ff <= {1'b1, txSh_ff[12:1]};
                    txLeft_ff <= txLeft_ff - 4'h1;
                    if (txLeft_ff == 4'h1)
                        txBusy_ff <= 1'b0;
                end
            end
        end
    end

    // two-flop synchroniser on the receive pin
    always @(posedge clk) begin
        if (sys_rst) begin
            rxMeta_ff <= 1'b1;
            rxSync_ff <= 1'b1;
            rxPrev_ff <= 1'b1;
        end else begin
            rxMeta_ff <= rxIn;
            rxSync_ff <= rxMeta_ff;
            rxPrev_ff <= rxSync_ff;
        end
    end

    // majority of three centre samples, disagreement is noise
    wire maj = (smp_ff[0] & smp_ff[1]) | (smp_ff[0] & rxSync_ff) |
               (smp_ff[1] & rxSync_ff);
    wire disagree = !((smp_ff[0] == smp_ff[1]) && (smp_ff[1] == rxSync_ff));
    wire atMid = tick & (rxTick_ff == `AST_SMP_C);
    wire atEnd = tick & (rxTick_ff == `AST_OVS_LAST);
    wire [3:0] rxBits = (nine ? 4'h9 : 4'h8) + {3'h0, parEn};
    wire [8:0] rxWord = nine ? rxSh_ff[8:0] : {1'b0, rxSh_ff[7:0]};
    wire rxParBit = nine ? rxSh_ff[9] : rxSh_ff[8];
    // parity error only possible with parity enabled
    wire rxPerr = parEn & (rxParBit != ((^rxWord) ^ parOdd));
    wire rxDone = (rxState_ff == RX_STOP) & atMid;
    // overrun blocks further transfers into the buffer
    wire rxPush = rxDone & !rxFullBuf & !overrun_flag_ff;
    wire rxLost = rxDone & (rxFullBuf | overrun_flag_ff);
    wire rxPop = dataRead & rxAvail;

    always @(posedge clk) begin
        if (sys_rst || !receiver_enable) begin
            rxState_ff <= RX_IDLE;
            rxTick_ff <= 4'h0;
            rxIdx_ff <= 4'h0;
            rxSh_ff <= 10'h000;
            smp_ff <= 2'h3;
            rxNoise_ff <= 1'b0;
        end else begin
            if (tick) begin
                rxTick_ff <= rxTick_ff + 4'h1;
                if (rxTick_ff == `AST_SMP_A)
                    smp_ff[0] <= rxSync_ff;
                if (rxTick_ff == `AST_SMP_B)
                    smp_ff[1] <= rxSync_ff;
            end
            if (atMid && disagree)
                rxNoise_ff <= 1'b1;
            case (rxState_ff)
                RX_IDLE: begin
                    if (rxPrev_ff && !rxSync_ff) begin
                        rxState_ff <= RX_START;
                        rxTick_ff <= 4'h0;
                        rxNoise_ff <= 1'b0;
                    end
                end
                RX_START: begin
                    // a glitch that is high at mid bit is no start
                    if (atMid && maj)
                        rxState_ff <= RX_IDLE;
                    else if (atEnd) begin
                        rxState_ff <= RX_DATA;
                        rxIdx_ff <= 4'h0;
                    end
                end
                RX_DATA: begin
                    if (atMid)
                        rxSh_ff[rxIdx_ff] <= maj;
                    if (atEnd) begin
                        rxIdx_ff <= rxIdx_ff + 4'h1;
                        if (rxIdx_ff == rxBits - 4'h1)
                            rxState_ff <= RX_STOP;
                    end
                end
                RX_STOP: begin
                    // back to idle at mid stop bit to resync early
                    if (atMid)
                        rxState_ff <= RX_IDLE;
                end
                default: rxState_ff <= RX_IDLE;
            endcase
        end
    end

    always @(posedge clk) begin
        if (sys_rst || !enable) begin
            rxWr_ff <= {RX_PW{1'b0}};
            rxRd_ff <= {RX_PW{1'b0}};
            rxCount_ff <= {(RX_PW+1){1'b0}};
        end else begin
            if (rxPush) begin
                rxMem[rxWr_ff] <= {rxNoise_ff | disagree, !maj, rxPerr,
                                   rxWord};
                rxWr_ff <= rxWr_ff + {{(RX_PW-1){1'b0}}, 1'b1};
            end
            // data read returns and drops the oldest word
            if (rxPop)
                rxRd_ff <= rxRd_ff + {{(RX_PW-1){1'b0}}, 1'b1};
            if (rxPush && !rxPop)
                rxCount_ff <= rxCount_ff + {{RX_PW{1'b0}}, 1'b1};
            else if (rxPop && !rxPush)
                rxCount_ff <= rxCount_ff - {{RX_PW{1'b0}}, 1'b1};
        end
    end

    // parity, noise and framing flags rise with the push, overrun with the loss; set wins over clear
    always @(posedge clk) begin
        if (sys_rst || !enable) begin
            parity_error_flag_ff <= 1'b0;
            noise_ff <= 1'b0;
            framing_error_flag_ff <= 1'b0;
            overrun_flag_ff <= 1'b0;
            statusArmed_ff <= 1'b0;
        end else begin
            if (doRead && rdSel == 3'h0)
                statusArmed_ff <= 1'b1;
            else if (dataAccess)
                statusArmed_ff <= 1'b0;
            parity_error_flag_ff <= (rxPush & rxPerr) | (parity_error_flag_ff & !seqClear);
            // noise flagged with the push, never on a lost word
            noise_ff <= (rxPush & (rxNoise_ff | disagree)) |
                        (noise_ff & !seqClear);
            framing_error_flag_ff <= (rxPush & !maj) | (framing_error_flag_ff & !seqClear);
            overrun_flag_ff <= rxLost | (overrun_flag_ff & !seqClear);
        end
    end

    // register writes; disabling clears direction enables and break
    always @(posedge clk) begin
        if (sys_rst) begin
            frameCtl_ff <= `AST_RST_FRAME;
            dirCtl_ff <= `AST_RST_DIRIRQ;
            baudDiv_ff <= `AST_RST_BAUD;
        end else begin
            if (doWrite && wLane0_ff && wrSel == 3'h1)
                frameCtl_ff <= (wData_ff & `AST_FC_WMASK) |
                               (frameCtl_ff & ~`AST_FC_WMASK);
            else if (!enable)
                frameCtl_ff[`AST_FC_BREAK] <= 1'b0;
            if (doWrite && wLane0_ff && wrSel == 3'h2)
                dirCtl_ff <= wData_ff;
            else if (!enable) begin
                dirCtl_ff[`AST_DC_TRANSMITTER_ENABLE] <= 1'b0;
                dirCtl_ff[`AST_DC_RECEIVER_ENABLE] <= 1'b0;
            end
            if (doWrite && wLane0_ff && wrSel == 3'h3)
                baudDiv_ff <= wData_ff;
        end
    end

    // axi4-lite slave: one write and one read in flight
    always @(posedge clk) begin
        if (sys_rst) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `AST_RESP_OKAY;
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= `AST_RESP_OKAY;
            s_axi_rdata <= 32'h00000000;
            awAddr_ff <= {ADDR_W{1'b0}};
            wData_ff <= 8'h00;
            wLane0_ff <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awAddr_ff <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wData_ff <= s_axi_wdata[7:0];
                wLane0_ff <= s_axi_wstrb[0];
                s_axi_wready <= 1'b0;
            end
            if (doWrite) begin
                s_axi_bvalid <= 1'b1;
                // status and other unmapped words refuse writes
                s_axi_bresp <= (wrSel == 3'h7 || wrSel == 3'h0) ?
                               `AST_RESP_SLVERR : `AST_RESP_OKAY;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
            if (doRead) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= (rdSel == 3'h7) ?
                               `AST_RESP_SLVERR : `AST_RESP_OKAY;
                if (rdSel == 3'h0)
                    s_axi_rdata <= {24'h000000, status};
                else if (rdSel == 3'h1)
                    s_axi_rdata <= {24'h000000, frameCtl_ff[7:2],
                                    rxHead[8], frameCtl_ff[0]};
                else if (rdSel == 3'h2)
                    s_axi_rdata <= {24'h000000, dirCtl_ff};
                else if (rdSel == 3'h3)
                    s_axi_rdata <= {24'h000000, baudDiv_ff};
                else if (rdSel == 3'h4)
                    s_axi_rdata <= {24'h000000,
                                    rxAvail ? rxHead[7:0] : 8'h00};
                else
                    s_axi_rdata <= 32'h00000000;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

    // pins, interrupt and wake, all registered
    always @(posedge clk) begin
        if (sys_rst) begin
            txOut <= 1'b1;
            txOe <= 1'b0;
            txPullDis <= 1'b0;
            rxPullDis <= 1'b0;
            irqReq <= 1'b0;
            wakeReq <= 1'b0;
        end else begin
            // enabled pins take their serial role, pull-ups off
            // disabled pins float, pull-up left to port logic
            txOe <= transmitter_enable;
            txPullDis <= transmitter_enable;
            rxPullDis <= receiver_enable;
            txOut <= txBusy_ff ? txSh_ff[0] :
                     !frameCtl_ff[`AST_FC_BREAK];
            // one request from every enabled source
            // address detect needs the last data bit set
            irqReq <= enable &
                ((dirCtl_ff[`AST_DC_RXIE] & rxAvail &
                  (!dirCtl_ff[`AST_DC_ADDR] | headMsb)) |
                 (dirCtl_ff[`AST_DC_RXIE] & overrun_flag_ff) |
                 (dirCtl_ff[`AST_DC_TIDLEIE] & txIdle & transmitter_enable) |
                 (dirCtl_ff[`AST_DC_TEMPTYIE] & txEmpty & transmitter_enable));
            // receive line low while idle wakes the device
            wakeReq <= receiver_enable & dirCtl_ff[`AST_DC_WAKE] & rxIdle & !rxSync_ff;
        end
    end
endmodule

// ==== tb/ast_uart_monitor.sv ====
// port checker for the serial transceiver
`timescale 1ns/1ps
module ast_uart_monitor (
    input wire clk,
    input wire sys_rst,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire txOut,
    input wire txOe,
    input wire txPullDis,
    input wire irqReq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    sequence wrTaken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence rdTaken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    chk_wr_answer: assert property (wrTaken |=>
        !s_axi_bvalid ##1 s_axi_bvalid)
        else $error("write answer not two edges after handshake");
    chk_rd_answer: assert property (rdTaken |=> s_axi_rvalid)
        else $error("read answer not one edge after handshake");
    chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write answer dropped before taken");
    chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer dropped before taken");
    chk_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address open while answer pending");
    chk_aw_block: assert property (s_axi_bvalid |->
        !s_axi_awready && !s_axi_wready)
        else $error("write channels open while answer pending");
    chk_rdata_upper: assert property (s_axi_rvalid |->
        s_axi_rdata[31:8] == 24'h000000)
        else $error("read data upper bits not zero");
    chk_tx_pull: assert property (txPullDis == txOe)
        else $error("transmit pull-up control disagrees with enable");
    chk_reset_out: assert property (disable iff (1'h0) sys_rst |=>
        s_axi_awready && !s_axi_bvalid && txOut && !txOe && !irqReq)
        else $error("outputs not at reset values");
endmodule

// ==== tb/ast_serial_peer.sv ====
// far-end serial device on the transmit and receive pins
`timescale 1ns/1ps
module ast_serial_peer (
    input wire logic clk,
    input wire logic txOut,
    input wire logic txOe,
    input wire logic [7:0] bitClks,
    output logic rxLine
);
    logic [10:0] capBits;
    int capCount = 0;
    initial rxLine = 1'h1;
    task automatic drive(input logic b);
        rxLine <= b;
        repeat (bitClks) @(posedge clk);
    endtask
    task automatic sendFrame(input logic [8:0] d,
        input logic nine, par, odd, badPar, badStop);
        drive(1'h0);
        for (int n = 0; n < (nine ? 9 : 8); n++)
            drive(d[n]);
        if (par)
            drive((nine ? ^d : ^d[7:0]) ^ odd ^ badPar);
        drive(!badStop);
        drive(1'h1);
    endtask
    initial forever begin
        @(negedge txOut);
        if (txOe) begin
            repeat (bitClks / 2) @(posedge clk);
            for (int i = 0; i < 11; i++) begin
                repeat (bitClks) @(posedge clk);
                capBits[i] = txOut;
            end
            capCount++;
        end
    end
endmodule

// ==== tb/test_ast_uart.sv ====
// self-checking bench for the serial transceiver
`timescale 1ns/1ps
`include "ast_regs.vh"
module test_ast_uart;
    typedef struct packed {
        logic [7:0] ctl;
        logic [7:0] d;
        logic [10:0] cap;
    } ast_row_t;
    // frame control, data, expected eleven bits after the start bit
    ast_row_t rows [5] = '{'{8'h80, 8'h55, 11'h755},
        '{8'hA0, 8'h37, 11'h737}, '{8'hB8, 8'hC4, 11'h6C4},
        '{8'hC1, 8'h0F, 11'h70F}, '{8'hF1, 8'h81, 11'h581}};
    logic clk = 1'h0;
    logic sysRst = 1'h1;
    logic [7:0] awAddr = 8'h00;
    logic [7:0] arAddr = 8'h00;
    logic [31:0] wData = 32'h0;
    logic awValid = 1'h0;
    logic wValid = 1'h0;
    // answers are always taken at once, so ready stays up
    logic bReady = 1'h1;
    logic arValid = 1'h0;
    logic rReady = 1'h1;
    logic wakeSeen = 1'h0;
    logic [31:0] v;
    logic [1:0] r;
    int n0;
    wire awReady, wReady, bValid, arReady, rValid;
    wire [1:0] bResp, rResp;
    wire [31:0] rData;
    wire txOut, txOe, txPullDis, rxPullDis, irqReq, wakeReq, rxLine;
    int errTotal = 0;
    int comparisons = 0;
    ast_uart dut (.clk(clk), .sys_rst(sysRst), .s_axi_awaddr(awAddr),
        .s_axi_awvalid(awValid), .s_axi_awready(awReady),
        .s_axi_wdata(wData), .s_axi_wstrb(4'hF), .s_axi_wvalid(wValid),
        .s_axi_wready(wReady), .s_axi_bresp(bResp), .s_axi_bvalid(bValid),
        .s_axi_bready(bReady), .s_axi_araddr(arAddr),
        .s_axi_arvalid(arValid), .s_axi_arready(arReady),
        .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid),
        .s_axi_rready(rReady), .txOut(txOut), .txOe(txOe),
        .txPullDis(txPullDis), .rxIn(rxLine), .rxPullDis(rxPullDis),
        .irqReq(irqReq), .wakeReq(wakeReq));
    ast_serial_peer peer (.clk(clk), .txOut(txOut), .txOe(txOe),
        .bitClks(8'h20), .rxLine(rxLine));
    initial forever #20 clk = ~clk;
    // wake request is a one-cycle pulse, so keep it sticky
    always @(posedge clk)
        if (wakeReq)
            wakeSeen <= 1'h1;
    task automatic chkVal(input logic [31:0] g, e);
        comparisons++;
        if (g !== e) begin
            errTotal++;
            $display("unexpected at %0t: got %h wanted %h", $time, g, e);
        end
    endtask
    task automatic chkResp(input logic [1:0] g, e);
        chkVal({30'h0, g}, {30'h0, e});
    endtask
    task automatic axWrite(input logic [7:0] a, d, output logic [1:0] q);
        awAddr <= a;
        wData <= {24'h000000, d};
        awValid <= 1'h1;
        wValid <= 1'h1;
        do begin
            @(posedge clk);
            if (awReady)
                awValid <= 1'h0;
            if (wReady)
                wValid <= 1'h0;
        end while (!bValid);
        q = bResp;
    endtask
    task automatic axRead(input logic [7:0] a, output logic [31:0] d,
        output logic [1:0] q);
        arAddr <= a;
        arValid <= 1'h1;
        do begin
            @(posedge clk);
            if (arReady)
                arValid <= 1'h0;
        end while (!rValid);
        d = rData;
        q = rResp;
    endtask
    task automatic wrReg(input logic [7:0] a, d);
        logic [1:0] q;
        axWrite(a, d, q);
        chkResp(q, `AST_RESP_OKAY);
    endtask
    task automatic rdChk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] d;
        logic [1:0] q;
        axRead(a, d, q);
        chkResp(q, `AST_RESP_OKAY);
        chkVal(d, e);
    endtask
    task automatic testDone();
        $display("comparisons %0d mismatches %0d", comparisons, errTotal);
        if (errTotal == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        repeat (60000) @(posedge clk);
        errTotal++;
        testDone();
    end
    initial begin
        repeat (3) @(posedge clk);
        sysRst <= 1'h0;
        wrReg(`AST_OFS_FRAME, 8'h80);
        wrReg(`AST_OFS_DIRIRQ, 8'hE0);
        wrReg(`AST_OFS_BAUD, 8'h01);
        @(posedge clk);
        chkVal({txOe, txPullDis, rxPullDis}, 32'h7);
        rdChk(`AST_OFS_STATUS, 32'h0B);
        foreach (rows[i]) begin
            wrReg(`AST_OFS_FRAME, rows[i].ctl);
            n0 = peer.capCount;
            wrReg(`AST_OFS_DATA, rows[i].d);
            repeat (800) if (peer.capCount == n0) @(posedge clk);
            chkVal(peer.capBits, rows[i].cap);
            peer.sendFrame({rows[i].ctl[0], rows[i].d}, rows[i].ctl[6],
                rows[i].ctl[5], rows[i].ctl[4], 1'h0, 1'h0);
            rdChk(`AST_OFS_STATUS, 32'h0F);
            axRead(`AST_OFS_FRAME, v, r);
            if (rows[i].ctl[6])
                chkVal(v[1], rows[i].ctl[0]);
            rdChk(`AST_OFS_DATA, rows[i].d);
        end
        $display("test format rows finished");
        wrReg(`AST_OFS_FRAME, 8'hA0);
        peer.sendFrame(9'h05A, 1'h0, 1'h1, 1'h0, 1'h1, 1'h0);
        rdChk(`AST_OFS_STATUS, 32'h8F);
        rdChk(`AST_OFS_DATA, 32'h5A);
        rdChk(`AST_OFS_STATUS, 32'h0B);
        wrReg(`AST_OFS_FRAME, 8'h80);
        peer.sendFrame(9'h0C3, 1'h0, 1'h0, 1'h0, 1'h0, 1'h1);
        rdChk(`AST_OFS_STATUS, 32'h2F);
        rdChk(`AST_OFS_DATA, 32'hC3);
        rdChk(`AST_OFS_STATUS, 32'h0B);
        $display("test receive errors finished");
        chkVal(wakeSeen, 1'h0);
        wrReg(`AST_OFS_DIRIRQ, 8'hEC);
        for (int k = 1; k < 4; k++)
            peer.sendFrame(9'h0A0 + 9'(k), 1'h0, 1'h0, 1'h0, 1'h0, 1'h0);
        chkVal(wakeSeen, 1'h1);
        chkVal(irqReq, 1'h1);
        rdChk(`AST_OFS_STATUS, 32'h1F);
        rdChk(`AST_OFS_DATA, 32'hA1);
        rdChk(`AST_OFS_DATA, 32'hA2);
        rdChk(`AST_OFS_STATUS, 32'h0B);
        chkVal(irqReq, 1'h0);
        wrReg(`AST_OFS_DIRIRQ, 8'hF4);
        peer.sendFrame(9'h05A, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0);
        chkVal(irqReq, 1'h0);
        $display("test overrun finished");
        wrReg(`AST_OFS_BAUD, 8'h07);
        wrReg(`AST_OFS_FRAME, 8'h00);
        @(posedge clk);
        chkVal({txOe, txPullDis, rxPullDis}, 32'h0);
        sysRst <= 1'h1;
        repeat (3) @(posedge clk);
        sysRst <= 1'h0;
        rdChk(`AST_OFS_BAUD, `AST_RST_BAUD);
        rdChk(`AST_OFS_STATUS, `AST_RST_STATUS);
        axWrite(`AST_OFS_STATUS, 8'h00, r);
        chkResp(r, `AST_RESP_SLVERR);
        axRead(8'h14, v, r);
        chkResp(r, `AST_RESP_SLVERR);
        $display("test reset and refusals finished");
        testDone();
    end
endmodule
bind ast_uart ast_uart_monitor mon (.clk(clk), .sys_rst(sys_rst),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .txOut(txOut), .txOe(txOe), .txPullDis(txPullDis), .irqReq(irqReq));
